// [rtl/lfd_pkg.sv]
package lfd_pkg;

    // =========================================================
    // Register map (byte offsets)
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_CONFIG   = 8'h04;
    localparam logic [7:0]  REG_TX_HEAD  = 8'h08;
    localparam logic [7:0]  REG_RX_HEAD  = 8'h0c;
    localparam logic [7:0]  REG_STATUS   = 8'h10;

    // Command register fields
    localparam int CMD_TX_GO   = 0;
    localparam int CMD_RX_GO   = 1;
    localparam int CMD_TX_ACK  = 8;
    localparam int CMD_RX_ACK  = 16;
    // Configuration register fields
    localparam int CFG_ONE_FRAG = 0;
    localparam logic CFG_RESET  = 1'b0;
    // Status register fields
    localparam int ST_TX_RUN   = 0;
    localparam int ST_RX_RUN   = 1;
    localparam int ST_TX_EOC   = 2;
    localparam int ST_RX_EOC   = 3;
    localparam int ST_FATAL    = 4;
    localparam int ST_TX_PEND  = 8;
    localparam int ST_RX_PEND  = 16;

    // =========================================================
    // Descriptor layout (word indices)
    localparam int DESC_FULL_WORDS = 22;
    localparam int DESC_ONE_WORDS  = 4;
    localparam int DESC_FWD        = 0;
    localparam int DESC_STAT       = 1;
    localparam int DESC_FRAG0      = 2;
    localparam int NUM_FRAGS       = 10;
    localparam logic [31:0] FWD_END    = 32'h0000_0000;
    localparam logic [31:0] FWD_MASK   = 32'hffff_fff8;
    localparam logic [31:0] STAT_OFS   = 32'h0000_0004;
    localparam int CS_FRM_CMP  = 14;
    localparam int CS_RX_EOC   = 11;
    localparam int CS_RX_ERR   = 10;
    localparam logic [15:0] CS_KEEP_MASK = 16'hb200;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [29:0] len;
    } lfd_mem_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
        logic        wdone;
    } lfd_mem_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [31:0] data;
    } lfd_tx_beat_t;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [2:0]  nbytes;
        logic [31:0] data;
    } lfd_rx_beat_t;

endpackage : lfd_pkg

// [rtl/lfd_dma.sv]
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
// Contract
// [RL1] One descriptor is one frame; follow forward pointer to next descriptor.
// [RL2] A buffer holds part or all of one frame; frames may span buffers.
// [RL3] Start command begins the channel using the current descriptor's buffers.
// [RL4] Linked descriptors are processed back to back without new start commands.
// [RL5] An all-zero forward pointer marks the last descriptor.
// [RL6] After finishing a descriptor, overwrite its status word with frame-complete set.
// [RL7] Host reclaims only after frame-complete, clears status, relinks at tail.
// [RL8] Host acknowledges how many frames it has processed.
// [RL9] Status bits 12 and 13 are ignored by the device; host writes ones.
// [RL10] Start fetches the whole 88-byte descriptor regardless of fragments used.
// [RL11] Single-fragment bit set fetches only a 16-byte receive descriptor.
// [RL12] Single-fragment applies to receive only; transmit always fetched full.
// [RL13] Host manages descriptors in memory; registers only for start and ack.
// [RL14] Descriptors are eight-byte aligned; low three pointer bits ignored.
// [RL15] Completed receive frame sets status bit 14.
// [RL16] After a zero-pointer frame, stop channel and raise end-of-chain event.
// [RL17] Transmit frame size must equal fragment count sum, else fatal state.
// [RL18] Fetch as ascending 32-bit read bursts; write status as one word.
module lfd_dma (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic [31:0]                reg_rdata_o,
    // Host memory master
    output lfd_pkg::lfd_mem_req_t      mem_req_o,
    input  wire lfd_pkg::lfd_mem_rsp_t mem_rsp_i,
    // Frame streams
    output lfd_pkg::lfd_tx_beat_t      tx_beat_o,
    input  wire lfd_pkg::lfd_rx_beat_t rx_beat_i,
    output logic                       rx_ready_o,
    // Events
    output logic                       tx_eoc_o,
    output logic                       rx_eoc_o,
    output logic                       fatal_o
);
    import lfd_pkg::*;

    typedef enum {
        S_IDLE, S_FETCH, S_FETCH_WAIT, S_CHECK, S_TX_REQ, S_TX_DATA,
        S_RX_FRAG, S_RX_WAIT, S_RX_WR, S_STAT_WR, S_STAT_WAIT, S_NEXT, S_FATAL
    } lfd_state_t;

    lfd_state_t  state;
    logic        network_config_reg;
    logic [31:0] tx_head;
    logic [31:0] rx_head;
    logic        tx_run;
    logic        rx_run;
    logic        tx_eoc;
    logic        rx_eoc;
    logic [7:0]  tx_pend;
    logic [7:0]  rx_pend;
    logic        is_rx;
    logic        last_rx;
    logic [31:0] desc_addr;
    logic [31:0] desc [DESC_FULL_WORDS];
    logic [4:0]  word_idx;
    logic [4:0]  word_cnt;
    logic [3:0]  frag;
    logic [29:0] words_left;
    logic [31:0] frag_off;
    logic [31:0] frag_left;
    logic [15:0] rx_size;
    logic        rx_err;
    logic        rx_done;
    logic        frame_done;

    logic        go_tx;
    logic        go_rx;
    logic        ack_err;
    logic [31:0] cur_cnt;
    logic [31:0] cur_addr;
    logic [31:0] next_cnt;
    logic [3:0]  frag_lim;
    logic [31:0] frag_sum;
    logic [15:0] stat_word;
    logic        fwd_zero;
    logic        rx_take;

    // =========================================================
    // Register writes
    assign go_tx = reg_wr_i && reg_addr_i == REG_CMD && reg_wdata_i[CMD_TX_GO];
    assign go_rx = reg_wr_i && reg_addr_i == REG_CMD && reg_wdata_i[CMD_RX_GO];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            network_config_reg <= CFG_RESET;
            tx_head            <= 32'h0000_0000;
            rx_head            <= 32'h0000_0000;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CONFIG:  network_config_reg <= reg_wdata_i[CFG_ONE_FRAG];
                REG_TX_HEAD: tx_head <= reg_wdata_i & FWD_MASK; // RL14
                REG_RX_HEAD: rx_head <= reg_wdata_i & FWD_MASK; // RL14
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CONFIG:  reg_rdata_o <= {31'h0000_0000, network_config_reg};
                REG_TX_HEAD: reg_rdata_o <= tx_head;
                REG_RX_HEAD: reg_rdata_o <= rx_head;
                REG_STATUS:  reg_rdata_o <= {8'h00, rx_pend, tx_pend, 3'h0,
                                             fatal_o, rx_eoc, tx_eoc, rx_run, tx_run};
                default:     reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // =========================================================
    // Channel run flags; a start is ignored while the channel runs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_run <= 1'b0;
            rx_run <= 1'b0;
        end else begin
            if (state == S_NEXT && fwd_zero && !is_rx) begin
                tx_run <= 1'b0; // RL16
            end else if (go_tx && state != S_FATAL) begin
                tx_run <= 1'b1; // RL3
            end
            if (state == S_NEXT && fwd_zero && is_rx) begin
                rx_run <= 1'b0; // RL16
            end else if (go_rx && state != S_FATAL) begin
                rx_run <= 1'b1; // RL3
            end
        end
    end

    // End-of-chain flags: sticky, write one to clear, set wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_eoc   <= 1'b0;
            rx_eoc   <= 1'b0;
            tx_eoc_o <= 1'b0;
            rx_eoc_o <= 1'b0;
        end else begin
            tx_eoc_o <= state == S_NEXT && fwd_zero && !is_rx;
            rx_eoc_o <= state == S_NEXT && fwd_zero && is_rx;
            if (state == S_NEXT && fwd_zero && !is_rx) begin
                tx_eoc <= 1'b1; // RL16
            end else if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[ST_TX_EOC]) begin
                tx_eoc <= 1'b0;
            end
            if (state == S_NEXT && fwd_zero && is_rx) begin
                rx_eoc <= 1'b1; // RL16
            end else if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[ST_RX_EOC]) begin
                rx_eoc <= 1'b0;
            end
        end
    end

    // Completed frames awaiting host acknowledgement
    assign ack_err = reg_wr_i && reg_addr_i == REG_CMD &&
                     ((reg_wdata_i[CMD_TX_ACK +: 8] > tx_pend) ||
                      (reg_wdata_i[CMD_RX_ACK +: 8] > rx_pend));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pend <= 8'h00;
            rx_pend <= 8'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_CMD && !ack_err) begin
                tx_pend <= tx_pend - reg_wdata_i[CMD_TX_ACK +: 8] +
                           {7'h00, frame_done && !is_rx}; // RL8
                rx_pend <= rx_pend - reg_wdata_i[CMD_RX_ACK +: 8] +
                           {7'h00, frame_done && is_rx}; // RL8
            end else begin
                tx_pend <= tx_pend + {7'h00, frame_done && !is_rx};
                rx_pend <= rx_pend + {7'h00, frame_done && is_rx};
            end
        end
    end

    // =========================================================
    // Descriptor views
    assign frag_lim = (is_rx && network_config_reg) ? 4'd1 : 4'(NUM_FRAGS); // RL11 RL12
    assign cur_cnt  = desc[DESC_FRAG0 + 2 * int'(frag)];
    assign cur_addr = desc[DESC_FRAG0 + 2 * int'(frag) + 1];
    assign next_cnt = (frag + 4'd1 < frag_lim) ? desc[DESC_FRAG0 + 2 * int'(frag) + 2]
                                               : 32'h0000_0000;
    assign fwd_zero = desc[DESC_FWD] == FWD_END; // RL5
    assign rx_take  = rx_ready_o && rx_beat_i.valid;

    always_comb begin
        frag_sum = 32'h0000_0000;
        for (int i = 0; i < NUM_FRAGS; i++) begin
            frag_sum = frag_sum + desc[DESC_FRAG0 + 2 * i];
        end
    end

    // Bits 12 and 13 pass through untouched and are never interpreted
    always_comb begin
        stat_word = desc[DESC_STAT][15:0] | (16'h0001 << CS_FRM_CMP); // RL6 RL9
        if (is_rx) begin
            stat_word = (desc[DESC_STAT][15:0] & CS_KEEP_MASK) |
                        (16'h0001 << CS_FRM_CMP); // RL15
            stat_word[CS_RX_EOC] = fwd_zero;
            stat_word[CS_RX_ERR] = rx_err;
        end
    end

    // =========================================================
    // Descriptor engine
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= S_IDLE;
            is_rx      <= 1'b0;
            last_rx    <= 1'b0;
            desc_addr  <= 32'h0000_0000;
            word_idx   <= 5'd0;
            word_cnt   <= 5'd0;
            frag       <= 4'd0;
            words_left <= 30'd0;
            frag_off   <= 32'h0000_0000;
            frag_left  <= 32'h0000_0000;
            rx_size    <= 16'h0000;
            rx_err     <= 1'b0;
            rx_done    <= 1'b0;
            frame_done <= 1'b0;
            fatal_o    <= 1'b0;
            mem_req_o  <= '0;
            tx_beat_o  <= '0;
            rx_ready_o <= 1'b0;
            for (int i = 0; i < DESC_FULL_WORDS; i++) begin
                desc[i] <= 32'h0000_0000;
            end
        end else begin
            mem_req_o.valid <= 1'b0;
            tx_beat_o.valid <= 1'b0;
            tx_beat_o.last  <= 1'b0;
            frame_done      <= 1'b0;
            if (ack_err) begin
                state   <= S_FATAL;
                fatal_o <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: begin
                        // Alternate channels between chains; a chain runs to its end before the other is served
                        if (rx_run && (!tx_run || !last_rx)) begin
                            is_rx     <= 1'b1;
                            last_rx   <= 1'b1;
                            desc_addr <= rx_head; // RL3
                            state     <= S_FETCH;
                        end else if (tx_run) begin
                            is_rx     <= 1'b0;
                            last_rx   <= 1'b0;
                            desc_addr <= tx_head; // RL3
                            state     <= S_FETCH;
                        end
                    end
                    S_FETCH: begin
                        word_idx  <= 5'd0;
                        word_cnt  <= (is_rx && network_config_reg) ?
                                     5'(DESC_ONE_WORDS) : 5'(DESC_FULL_WORDS); // RL10 RL11 RL12
                        mem_req_o <= '{valid: 1'b1, write: 1'b0, addr: desc_addr,
                                       wdata: 32'h0000_0000,
                                       len: (is_rx && network_config_reg) ?
                                            30'(DESC_ONE_WORDS) :
                                            30'(DESC_FULL_WORDS)}; // RL18
                        state     <= S_FETCH_WAIT;
                    end
                    S_FETCH_WAIT: begin
                        if (mem_rsp_i.rvalid) begin
                            desc[word_idx] <= mem_rsp_i.rdata; // RL18
                            word_idx       <= word_idx + 5'd1;
                            if (word_idx + 5'd1 == word_cnt) begin
                                state <= S_CHECK;
                            end
                        end
                    end
                    S_CHECK: begin
                        frag      <= 4'd0;
                        rx_size   <= 16'h0000;
                        rx_err    <= 1'b0;
                        rx_done   <= 1'b0;
                        if (is_rx && network_config_reg) begin
                            // Unfetched fragment slots must not leak old counts
                            for (int i = DESC_ONE_WORDS; i < DESC_FULL_WORDS; i++) begin
                                desc[i] <= 32'h0000_0000;
                            end
                        end
                        if (!is_rx && frag_sum != {16'h0000, desc[DESC_STAT][31:16]}) begin
                            state   <= S_FATAL; // RL17
                            fatal_o <= 1'b1;
                        end else begin
                            state <= is_rx ? S_RX_FRAG : S_TX_REQ;
                        end
                    end
                    S_TX_REQ: begin
                        // A zero count ends the fragment list of this frame
                        if (frag == frag_lim || cur_cnt == 32'h0000_0000) begin
                            state <= S_STAT_WR; // RL2
                        end else begin
                            words_left <= 30'((cur_cnt + 32'd3) >> 2);
                            mem_req_o  <= '{valid: 1'b1, write: 1'b0, addr: cur_addr,
                                            wdata: 32'h0000_0000,
                                            len: 30'((cur_cnt + 32'd3) >> 2)};
                            state      <= S_TX_DATA;
                        end
                    end
                    S_TX_DATA: begin
                        if (mem_rsp_i.rvalid) begin
                            tx_beat_o.valid <= 1'b1;
                            tx_beat_o.data  <= mem_rsp_i.rdata;
                            tx_beat_o.last  <= words_left == 30'd1 &&
                                               next_cnt == 32'h0000_0000; // RL1
                            words_left      <= words_left - 30'd1;
                            if (words_left == 30'd1) begin
                                frag  <= frag + 4'd1;
                                state <= S_TX_REQ;
                            end
                        end
                    end
                    S_RX_FRAG: begin
                        frag_off   <= 32'h0000_0000;
                        frag_left  <= cur_cnt;
                        rx_ready_o <= 1'b1;
                        state      <= S_RX_WAIT;
                        if (frag == frag_lim || cur_cnt == 32'h0000_0000) begin
                            rx_err <= 1'b1; // Out of buffer space: rest is dropped
                        end
                    end
                    S_RX_WAIT: begin
                        if (rx_take) begin
                            rx_ready_o <= 1'b0;
                            rx_size    <= rx_size + {13'h0000, rx_beat_i.nbytes};
                            rx_done    <= rx_beat_i.last;
                            if (rx_err) begin
                                rx_ready_o <= !rx_beat_i.last;
                                state      <= rx_beat_i.last ? S_STAT_WR : S_RX_WAIT;
                            end else begin
                                mem_req_o <= '{valid: 1'b1, write: 1'b1,
                                               addr: cur_addr + frag_off,
                                               wdata: rx_beat_i.data, len: 30'd1};
                                state     <= S_RX_WR;
                            end
                        end
                    end
                    S_RX_WR: begin
                        if (mem_rsp_i.wdone) begin
                            frag_off  <= frag_off + 32'd4;
                            frag_left <= (frag_left > 32'd4) ? frag_left - 32'd4
                                                             : 32'h0000_0000;
                            if (rx_done) begin
                                state <= S_STAT_WR; // RL2
                            end else if (frag_left <= 32'd4) begin
                                frag  <= frag + 4'd1;
                                state <= S_RX_FRAG;
                            end else begin
                                rx_ready_o <= 1'b1;
                                state      <= S_RX_WAIT;
                            end
                        end
                    end
                    S_STAT_WR: begin
                        mem_req_o <= '{valid: 1'b1, write: 1'b1,
                                       addr: desc_addr + STAT_OFS,
                                       wdata: {is_rx ? rx_size : desc[DESC_STAT][31:16],
                                               stat_word},
                                       len: 30'd1}; // RL6 RL18
                        state     <= S_STAT_WAIT;
                    end
                    S_STAT_WAIT: begin
                        if (mem_rsp_i.wdone) begin
                            frame_done <= 1'b1;
                            state      <= S_NEXT;
                        end
                    end
                    S_NEXT: begin
                        if (fwd_zero) begin
                            state <= S_IDLE; // RL16
                        end else begin
                            desc_addr <= desc[DESC_FWD] & FWD_MASK; // RL1 RL14
                            state     <= S_FETCH; // RL4
                        end
                    end
                    S_FATAL: begin
                        rx_ready_o <= 1'b0;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

endmodule : lfd_dma

// [testbench/lfd_dma_checker.sv]
`timescale 1ns/1ns
// ============================================
// Port checker for the list processor
module lfd_dma_checker (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    // Register port
    input wire logic                  reg_rd_i,
    input wire logic [31:0]           reg_rdata_o,
    // Memory and streams
    input wire lfd_pkg::lfd_mem_req_t mem_req_o,
    input wire lfd_pkg::lfd_rx_beat_t rx_beat_i,
    input wire logic                  rx_ready_o,
    // Events
    input wire logic                  tx_eoc_o,
    input wire logic                  rx_eoc_o,
    input wire logic                  fatal_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr_req;
        mem_req_o.valid && mem_req_o.write;
    endsequence
    sequence s_rx_take;
        rx_ready_o && rx_beat_i.valid;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_req_pulse: assert property (mem_req_o.valid |=> !mem_req_o.valid)
        else $error("memory request longer than one cycle");
    a_wr_one_word: assert property (s_wr_req |-> mem_req_o.len == 30'h1)
        else $error("write not a single word");
    a_tx_eoc_pulse: assert property (tx_eoc_o |=> !tx_eoc_o)
        else $error("tx end of chain not a pulse");
    a_rx_eoc_pulse: assert property (rx_eoc_o |=> !rx_eoc_o)
        else $error("rx end of chain not a pulse");
    a_fatal_holds: assert property (fatal_o |=> fatal_o)
        else $error("fatal state left without reset");
    a_eoc_quiet: assert property (tx_eoc_o |-> !mem_req_o.valid [*2])
        else $error("memory traffic after channel stop");
    a_rx_take_drop: assert property (s_rx_take ##1 s_wr_req |-> !rx_ready_o &&
        mem_req_o.wdata == $past(rx_beat_i.data))
        else $error("ready held or wrong word written after a receive take");
endmodule : lfd_dma_checker

// [testbench/lfd_mem_model.sv]
`timescale 1ns/1ns
// ============================================
// Host memory on the bus master side
module lfd_mem_model (
    input  wire logic                  clk_i,
    input  wire lfd_pkg::lfd_mem_req_t req_i,
    input  wire logic [3:0]            lat_i,
    output lfd_pkg::lfd_mem_rsp_t      rsp_o
);
    import lfd_pkg::*;
    logic [31:0]  mem [0:255];
    lfd_mem_req_t r;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h0;
        rsp_o = '0;
        forever begin
            @(posedge clk_i);
            if (req_i.valid) begin
                r = req_i;
                repeat (lat_i) @(posedge clk_i);
                // Ascending beats, idle data toggles
                for (int i = 0; i < r.len; i++) begin
                    if (r.write) mem[r.addr[9:2]] = r.wdata;
                    rsp_o <= {!r.write, r.write ? ~rsp_o.rdata : mem[r.addr[9:2] + i], r.write};
                    @(posedge clk_i);
                end
                rsp_o <= {1'b0, ~rsp_o.rdata, 1'b0};
            end
        end
    end
endmodule : lfd_mem_model

// [testbench/lfd_dma_tb_top.sv]
`timescale 1ns/1ns
// ============================================
// Testbench top
module lfd_dma_tb_top;
    import lfd_pkg::*;
    logic         clk_i, rst_i, reg_wr_i, reg_rd_i, rx_ready_o, tx_eoc_o, rx_eoc_o, fatal_o;
    logic [7:0]   reg_addr_i;
    logic [31:0]  reg_wdata_i, reg_rdata_o;
    logic [3:0]   lat;
    lfd_mem_req_t mem_req_o;
    lfd_mem_rsp_t mem_rsp_i;
    lfd_tx_beat_t tx_beat_o;
    lfd_rx_beat_t rx_beat_i;
    int           failures, samples_checked, nbeat;
    logic [31:0]  lens [$];
    wire logic [3:0] ev = {rx_ready_o, fatal_o, rx_eoc_o, tx_eoc_o};
    lfd_dma u_lfd_dma (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .mem_req_o, .mem_rsp_i, .tx_beat_o, .rx_beat_i, .rx_ready_o,
        .tx_eoc_o, .rx_eoc_o, .fatal_o);
    lfd_mem_model u_lfd_mem_model (.clk_i, .req_i(mem_req_o), .lat_i(lat), .rsp_o(mem_rsp_i));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (mem_req_o.valid && !mem_req_o.write) lens.push_back(32'(mem_req_o.len));
        if (tx_beat_o.valid) chk(tx_beat_o.data, u_lfd_mem_model.mem[192 + nbeat]);
        if (tx_beat_o.valid) chk(32'(tx_beat_o.last), 32'(nbeat != 0));
        if (tx_beat_o.valid) nbeat++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        if (!w) chk(reg_rdata_o, d);
    endtask : bus
    task automatic wait_ev(input int b);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ev[b] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            failures++;
            $display("MISMATCH %0t wait timed out", $time);
            finish_test();
        end
    endtask : wait_ev
    task automatic rx_word(input logic [31:0] d, input logic l);
        rx_beat_i <= {1'b1, l, 3'h4, d};
        wait_ev(3);
    endtask : rx_word
    // Host builds one cleared descriptor with one fragment
    task automatic desc(input int w, input logic [31:0] fwd, szst, cnt, ba);
        for (int i = 0; i < 22; i++) u_lfd_mem_model.mem[w + i] = 32'h0;
        u_lfd_mem_model.mem[w] = fwd;
        u_lfd_mem_model.mem[w + 1] = szst;
        u_lfd_mem_model.mem[w + 2] = cnt;
        u_lfd_mem_model.mem[w + 3] = ba;
    endtask : desc
    task automatic rx_one_frag;
        desc(96, 32'h0, 32'h0000_3000, 32'h8, 32'h380);
        lat <= 4'h3;
        lens.delete();
        bus(1'b1, REG_CONFIG, 32'h1);
        bus(1'b1, REG_CMD, 32'h2);
        rx_word(32'ha5a5_0001, 1'b0);
        rx_word(32'ha5a5_0002, 1'b1);
        rx_beat_i <= '0;
        wait_ev(1);
        chk(32'(lens.size()), 32'h1);
        chk(lens[0], 32'h4);
        chk(u_lfd_mem_model.mem[225], 32'ha5a5_0002);
        chk(u_lfd_mem_model.mem[97], 32'h0008_7800);
        bus(1'b0, REG_STATUS, 32'h0001_0008);
        bus(1'b1, REG_STATUS, 32'h8);
        bus(1'b1, REG_CMD, 32'h0001_0000);
        bus(1'b0, REG_STATUS, 32'h0);
    endtask : rx_one_frag
    task automatic tx_chain;
        desc(64, 32'h0000_0203, 32'h0008_3000, 32'h8, 32'h300);
        desc(128, 32'h0, 32'h0004_3000, 32'h4, 32'h308);
        for (int i = 0; i < 3; i++) u_lfd_mem_model.mem[192 + i] = 32'hc0de_0000 + i;
        lat <= 4'h0;
        nbeat = 0;
        lens.delete();
        bus(1'b1, REG_TX_HEAD, 32'h100);
        bus(1'b1, REG_CMD, 32'h1);
        wait_ev(0);
        chk(32'(nbeat), 32'h3);
        chk(lens[0], 32'd22);
        chk(lens[1], 32'h2);
        chk(lens[2], 32'd22);
        chk(u_lfd_mem_model.mem[65], 32'h0008_7000);
        chk(u_lfd_mem_model.mem[129], 32'h0004_7000);
        bus(1'b0, REG_STATUS, 32'h0000_0204);
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b1, REG_CMD, 32'h0000_0200);
        bus(1'b0, REG_STATUS, 32'h0);
    endtask : tx_chain
    task automatic tx_bad_size;
        desc(64, 32'h0, 32'h0006_3000, 32'h8, 32'h300);
        bus(1'b1, REG_CMD, 32'h1);
        wait_ev(2);
        chk(u_lfd_mem_model.mem[65], 32'h0006_3000);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0);
    endtask : tx_bad_size
    task automatic finish_test;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, rx_beat_i, lat} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, REG_CONFIG, 32'h0);
        bus(1'b1, 8'h40, 32'hffff_ffff);
        bus(1'b0, 8'h40, 32'h0);
        bus(1'b1, REG_RX_HEAD, 32'h0000_0187);
        bus(1'b0, REG_RX_HEAD, 32'h0000_0180);
        rx_one_frag();
        tx_chain();
        tx_bad_size();
        finish_test();
    end
endmodule : lfd_dma_tb_top
bind lfd_dma lfd_dma_checker u_lfd_dma_checker (.clk_i, .rst_i, .reg_rd_i, .reg_rdata_o,
    .mem_req_o, .rx_beat_i, .rx_ready_o, .tx_eoc_o, .rx_eoc_o, .fatal_o);
